/* usart_baud_and_frame_config.sv */
// Serial transceiver with baud generator, frame format control and APB registers.
// Assumes APB master on clk_sys; serial pins come from outside and are synchronised here.
// Behaviour
// - The baud down-counter runs at the system clock and reloads with the divisor at zero or on a low-byte write.
// - Every zero of the down-counter gives one baud tick, so the tick rate is clock over divisor plus one.
// - In async and sync master modes the transmitter bit clock is the baud tick divided by 16, 8 or 2 depending on mode.
// - The receiver works directly from baud ticks with 16 or 8 states per bit from speed in async mode; sync mode samples on the receive clock edge.
// - The internal baud tick clocks async and sync master modes, but not sync slave mode.
// - Sync slave clocks from the external clock pin; sync master drives its own clock onto that pin.
// - Frame control shares its address with the divisor high byte; bit 7 reads one and selects control on write.
// - Bit 6 picks asynchronous operation at zero and synchronous operation at one.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd, for both generation and checking.
// - With parity on, the transmitter sends the parity of the frame data bits inside the frame.
// - With parity on, the receiver checks incoming parity and sets the parity error flag on mismatch.
// - Bit 3 gives one stop bit at zero and two at one for the transmitter; the receiver ignores it.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
module usart_baud_and_frame_config
    import usart_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic rxd,
    output logic txd,
    input wire logic ext_clock_pin_in,
    output logic ext_clock_pin_out,
    output logic ext_clock_pin_oe_n
);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    wire logic setup_phase = psel & ~penable;
    wire logic wr_en = psel & penable & pwrite;
    wire logic hit_baud_lo = (paddr == OFS_BAUD_LO);
    wire logic hit_shared = (paddr == OFS_SHARED);
    wire logic hit_aux = (paddr == OFS_AUX_CTRL);
    wire logic hit_data = (paddr == OFS_DATA);
    wire logic hit_status = (paddr == OFS_STATUS);
    wire logic hit_irq_stat = (paddr == OFS_IRQ_STAT);
    wire logic hit_irq_clr = (paddr == OFS_IRQ_CLR);
    wire logic hit_irq_en = (paddr == OFS_IRQ_EN);
    wire logic hit_any = hit_baud_lo | hit_shared | hit_aux | hit_data | hit_status | hit_irq_stat
                         | hit_irq_clr | hit_irq_en;
    wire logic wr_baud_lo = wr_en & hit_baud_lo;
    wire logic wr_data = wr_en & hit_data;
    wire logic wr_ffc = wr_en & hit_shared & pwdata[7];
    wire logic wr_div_hi = wr_en & hit_shared & ~pwdata[7];

    frame_ctrl_t ffc_r;
    aux_ctrl_t aux_r;
    status_t status;
    logic [DIV_W-1:0] divisor_r;
    logic [DIV_W-1:0] baud_cnt_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic [DATA_W-1:0] rx_data_r;
    logic parity_err_r;
    logic frame_err_r;
    logic [31:0] rd_mux;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ffc_r <= FFC_RESET;
            aux_r <= AUX_RESET;
            divisor_r <= DIV_RESET;
            irq_en_r <= '0;
        end
        else
        begin
            if (wr_ffc)
                ffc_r <= frame_ctrl_t'({1'b1, pwdata[6:0]});
            if (wr_div_hi)
                divisor_r[DIV_W-1 -: DIV_HI_W] <= pwdata[DIV_HI_W-1:0];
            if (wr_baud_lo)
                divisor_r[7:0] <= pwdata[7:0];
            if (wr_en & hit_aux)
                aux_r <= aux_ctrl_t'({4'h0, pwdata[3:0]});
            if (wr_en & hit_irq_en)
                irq_en_r <= pwdata[IRQ_W-1:0];
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait state
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_baud_lo)
            rd_mux = {24'h000000, divisor_r[7:0]};
        // shared address reads as control with select high
        else if (hit_shared)
            rd_mux = {24'h000000, 1'b1, ffc_r[6:0]};
        else if (hit_aux)
            rd_mux = {24'h000000, aux_r};
        else if (hit_data)
            rd_mux = {23'h000000, rx_data_r};
        else if (hit_status)
            rd_mux = {24'h000000, status};
        else if (hit_irq_stat)
            rd_mux = {28'h0000000, irq_stat_r};
        else if (hit_irq_en)
            rd_mux = {28'h0000000, irq_en_r};
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= rd_mux;
            pslverr <= ~hit_any;
        end
    end

    assign pready = 1'b1;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] rxd_sync_r;
    logic [2:0] xck_sync_r;
    logic rxd_f_r;
    logic xck_f_r;
    logic xck_f_d_r;

    // A change counts only once the second and third stages agree
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rxd_sync_r <= 3'h7;
            xck_sync_r <= 3'h0;
            rxd_f_r <= 1'b1;
            xck_f_r <= 1'b0;
            xck_f_d_r <= 1'b0;
        end
        else
        begin
            rxd_sync_r <= {rxd_sync_r[1:0], rxd};
            xck_sync_r <= {xck_sync_r[1:0], ext_clock_pin_in};
            if (rxd_sync_r[1] == rxd_sync_r[2])
                rxd_f_r <= rxd_sync_r[2];
            if (xck_sync_r[1] == xck_sync_r[2])
                xck_f_r <= xck_sync_r[2];
            xck_f_d_r <= xck_f_r;
        end
    end

    // ----------------------------------------------------------------
    // Baud generator and bit clocks
    // ----------------------------------------------------------------
    // zero async, one sync
    wire logic sync_mode = ffc_r.sync_mode_select;
    wire logic sync_master = sync_mode & aux_r.ext_clock_direction;
    wire logic sync_slave = sync_mode & ~aux_r.ext_clock_direction;
    wire logic baud_tick = (baud_cnt_r == '0);
    // states per bit from mode and speed
    wire logic [4:0] ratio = sync_mode ? RATIO_SYNC : (aux_r.double_speed ? RATIO_DOUBLE : RATIO_NORMAL);
    logic xck_r;

    // reload on zero or low byte write
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            baud_cnt_r <= DIV_RESET;
        else if (baud_tick | wr_baud_lo)
            baud_cnt_r <= wr_baud_lo ? {divisor_r[DIV_W-1 -: DIV_HI_W], pwdata[7:0]} : divisor_r;
        else
            baud_cnt_r <= baud_cnt_r - 1'b1;
    end

    // master divides the baud tick by two onto the clock pin
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst | ~sync_master)
            xck_r <= 1'b0;
        else if (baud_tick)
            xck_r <= ~xck_r;
    end

    assign ext_clock_pin_out = xck_r ^ ffc_r.sync_clock_polarity;
    // pin driven only as sync master
    assign ext_clock_pin_oe_n = ~sync_master;

    // slave edges come from the pin, otherwise from the baud tick
    wire logic m_rise = sync_master & baud_tick & ~xck_r;
    wire logic m_fall = sync_master & baud_tick & xck_r;
    wire logic s_rise = sync_slave & xck_f_r & ~xck_f_d_r;
    wire logic s_fall = sync_slave & ~xck_f_r & xck_f_d_r;
    wire logic clk_rise = m_rise | s_rise;
    wire logic clk_fall = m_fall | s_fall;
    wire logic tx_edge = ffc_r.sync_clock_polarity ? clk_fall : clk_rise;
    wire logic rx_edge = ffc_r.sync_clock_polarity ? clk_rise : clk_fall;

    // ----------------------------------------------------------------
    // Frame format
    // ----------------------------------------------------------------
    // 01 is reserved and treated as no parity
    wire logic par_on = ffc_r.parity_mode[1];
    wire logic par_odd = (ffc_r.parity_mode == PAR_ODD);
    wire logic [3:0] nbits = aux_r.char_size_nine ? NINE_DATA_BITS
                                                  : MIN_DATA_BITS + {2'b00, ffc_r.char_size};

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    tx_state_t tx_state_r;
    logic [DATA_W-1:0] tx_shift_r;
    logic [3:0] tx_cnt_r;
    logic [4:0] tx_div_r;
    logic tx_par_r;
    logic tx_done;

    // async bit clock divides baud ticks by the mode ratio
    wire logic tx_bit_tick = sync_mode ? tx_edge : (baud_tick && tx_div_r == ratio - 5'h01);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst | (tx_state_r == TX_IDLE) | tx_bit_tick)
            tx_div_r <= 5'h00;
        else if (baud_tick)
            tx_div_r <= tx_div_r + 5'h01;
    end

    assign tx_done = tx_bit_tick & ((tx_state_r == TX_STOP2) | ((tx_state_r == TX_STOP1) & ~ffc_r.stop_bits_select));

    // start, data LSB first, parity, stop
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            tx_state_r <= TX_IDLE;
            tx_shift_r <= '0;
            tx_cnt_r <= 4'h0;
            tx_par_r <= 1'b0;
            txd <= 1'b1;
        end
        else
        begin
            case (tx_state_r)
                TX_IDLE:
                    if (wr_data)
                    begin
                        // ninth bit is taken from the earlier control write
                        tx_shift_r <= {aux_r.tx_ninth_bit, pwdata[7:0]};
                        tx_cnt_r <= 4'h0;
                        tx_par_r <= par_odd;
                        txd <= 1'b0;
                        tx_state_r <= TX_START;
                    end
                TX_START:
                    if (tx_bit_tick)
                    begin
                        txd <= tx_shift_r[0];
                        tx_state_r <= TX_DATA;
                    end
                TX_DATA:
                    if (tx_bit_tick)
                    begin
                        // parity accumulates over sent data bits
                        tx_par_r <= tx_par_r ^ tx_shift_r[0];
                        tx_shift_r <= {1'b0, tx_shift_r[DATA_W-1:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                        if (tx_cnt_r == nbits - 4'h1)
                        begin
                            txd <= par_on ? (tx_par_r ^ tx_shift_r[0]) : 1'b1;
                            tx_state_r <= par_on ? TX_PARITY : TX_STOP1;
                        end
                        else
                            txd <= tx_shift_r[1];
                    end
                TX_PARITY:
                    if (tx_bit_tick)
                    begin
                        txd <= 1'b1;
                        tx_state_r <= TX_STOP1;
                    end
                // second stop bit only when selected
                TX_STOP1:
                    if (tx_bit_tick)
                        tx_state_r <= ffc_r.stop_bits_select ? TX_STOP2 : TX_IDLE;
                TX_STOP2:
                    if (tx_bit_tick)
                        tx_state_r <= TX_IDLE;
                default:
                    tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    rx_state_t rx_state_r;
    logic [4:0] rx_phase_r;
    logic [3:0] rx_cnt_r;
    logic [DATA_W-1:0] rx_shift_r;
    logic rx_par_r;
    logic rx_par_bad_r;

    // async samples mid-bit from raw baud ticks; sync samples on the receive edge
    wire logic [4:0] rx_target = (rx_state_r == RX_START) ? (ratio >> 1) - 5'h01 : ratio - 5'h01;
    wire logic rx_sample = sync_mode ? rx_edge : (baud_tick && rx_phase_r == rx_target);
    // First bit enters at the top, so short characters must be shifted down to bit zero
    wire logic [DATA_W-1:0] rx_word = rx_shift_r >> (NINE_DATA_BITS - nbits);
    wire logic rx_done = rx_sample & (rx_state_r == RX_STOP);
    wire logic rx_par_err = rx_sample & (rx_state_r == RX_PARITY) & (rxd_f_r != (rx_par_r ^ par_odd));

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst | (rx_state_r == RX_IDLE) | rx_sample)
            rx_phase_r <= 5'h00;
        else if (baud_tick)
            rx_phase_r <= rx_phase_r + 5'h01;
    end

    // receiver checks one stop bit whatever the select
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= 4'h0;
            rx_shift_r <= '0;
            rx_par_r <= 1'b0;
            rx_par_bad_r <= 1'b0;
            rx_data_r <= '0;
            parity_err_r <= 1'b0;
            frame_err_r <= 1'b0;
        end
        else
        begin
            case (rx_state_r)
                RX_IDLE:
                begin
                    rx_cnt_r <= 4'h0;
                    rx_par_r <= 1'b0;
                    rx_par_bad_r <= 1'b0;
                    if (~sync_mode & ~rxd_f_r)
                        rx_state_r <= RX_START;
                    else if (sync_mode & rx_edge & ~rxd_f_r)
                        rx_state_r <= RX_DATA;
                end
                // Start bit rechecked mid-bit to reject glitches
                RX_START:
                    if (rx_sample)
                        rx_state_r <= rxd_f_r ? RX_IDLE : RX_DATA;
                RX_DATA:
                    if (rx_sample)
                    begin
                        rx_shift_r <= {rxd_f_r, rx_shift_r[DATA_W-1:1]};
                        rx_par_r <= rx_par_r ^ rxd_f_r;
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r == nbits - 4'h1)
                            rx_state_r <= par_on ? RX_PARITY : RX_STOP;
                    end
                RX_PARITY:
                    if (rx_sample)
                    begin
                        rx_par_bad_r <= rx_par_err;
                        rx_state_r <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_sample)
                    begin
                        rx_data_r <= rx_word;
                        parity_err_r <= rx_par_bad_r;
                        frame_err_r <= ~rxd_f_r;
                        rx_state_r <= RX_IDLE;
                    end
                default:
                    rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Status and interrupts
    // ----------------------------------------------------------------
    assign status = '{spare: 3'h0, rx_ninth_bit: rx_data_r[8], frame_error_flag: frame_err_r,
                      parity_error_flag: parity_err_r, rx_busy: (rx_state_r != RX_IDLE),
                      tx_busy: (tx_state_r != TX_IDLE)};

    wire logic [IRQ_W-1:0] irq_events = {rx_done & ~rxd_f_r, rx_par_err, rx_done, tx_done};
    wire logic [IRQ_W-1:0] irq_clr = (wr_en & hit_irq_clr) ? pwdata[IRQ_W-1:0] : '0;

    // A new event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            irq_stat_r <= '0;
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_events;
    end

    assign irq = |(irq_stat_r & irq_en_r);

endmodule

/* usart_cfg_pkg.sv */
// Constants, register layouts and state types for the serial transceiver core.
// Assumes a single 125 MHz system clock and an APB register port with 32-bit data.
package usart_cfg_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_BAUD_LO = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_SHARED = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_AUX_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_DATA = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h01c;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    localparam int DIV_W = 12;
    localparam int DIV_HI_W = 4;
    localparam int DATA_W = 9;

    typedef struct packed {
        logic shared_addr_select;
        logic sync_mode_select;
        logic [1:0] parity_mode;
        logic stop_bits_select;
        logic [1:0] char_size;
        logic sync_clock_polarity;
    } frame_ctrl_t;

    typedef struct packed {
        logic [3:0] spare;
        logic char_size_nine;
        logic tx_ninth_bit;
        logic ext_clock_direction;
        logic double_speed;
    } aux_ctrl_t;

    typedef struct packed {
        logic [2:0] spare;
        logic rx_ninth_bit;
        logic frame_error_flag;
        logic parity_error_flag;
        logic rx_busy;
        logic tx_busy;
    } status_t;

    localparam frame_ctrl_t FFC_RESET = 8'h86;
    localparam aux_ctrl_t AUX_RESET = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;

    localparam logic [1:0] PAR_OFF = 2'h0;
    localparam logic [1:0] PAR_RSVD = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;

    // Baud ticks per bit for each mode
    localparam logic [4:0] RATIO_NORMAL = 5'h10;
    localparam logic [4:0] RATIO_DOUBLE = 5'h08;
    localparam logic [4:0] RATIO_SYNC = 5'h02;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] NINE_DATA_BITS = 4'h9;

    // Interrupt event bits
    localparam int IRQ_W = 4;
    localparam int IRQ_TX_DONE = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_PAR_ERR = 2;
    localparam int IRQ_FRAME_ERR = 3;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage

/* usart_baud_and_frame_config_assertions.sv */
// Checker for the serial transceiver's APB port, interrupt and line pins.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module usart_cfg_checker
    import usart_cfg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic txd,
    input wire logic ext_clock_pin_oe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic acc = psel && penable;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("access without ready");
    property p_err; acc && paddr > OFS_IRQ_EN |-> pslverr && (pwrite || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; acc && paddr <= OFS_IRQ_EN && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_sel; acc && !pwrite && paddr == OFS_SHARED |-> prdata[7]; endproperty
    a_sel: assert property (p_sel) else $error("shared read bit 7 low");
    property p_hold; !psel |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved while idle");
    property p_mask; acc && pwrite && paddr == OFS_IRQ_EN && pwdata[3:0] == 4'h0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt still high");
    property p_start; $fell(txd) |-> !txd [*2]; endproperty
    a_start: assert property (p_start) else $error("start bit too short");
    property p_rst; $fell(sys_rst) |-> txd && ext_clock_pin_oe_n && !irq; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
endmodule
bind usart_baud_and_frame_config usart_cfg_checker chk_u (.*);

/* serial_peer_model.sv */
// Remote serial peer: samples frames on txd and sends frames on rxd.
// Assumes the bench calls its tasks right after a clock edge and knows the bit time.
`timescale 1ns/10ps
module serial_peer_model
(
    input wire logic clk_sys,
    input wire logic txd,
    output logic rxd
);
    int cyc = 0;
    always @(posedge clk_sys) cyc <= cyc + 1;
    initial rxd = 1'b1;
    task automatic send(input logic [15:0] v, input int nb, input int bl);
        for (int i = 0; i < nb; i++)
        begin
            rxd <= v[i];
            repeat (bl) @(posedge clk_sys);
        end
        rxd <= 1'b1;
    endtask
    task automatic take(input int nb, input int bl, output logic [15:0] v, output int t0);
        int k;
        v = '1;
        k = 0;
        while (txd !== 1'b0 && k < 4000)
        begin
            @(posedge clk_sys);
            k++;
        end
        t0 = cyc;
        for (int i = 0; i < nb; i++)
        begin
            repeat (i == 0 ? bl / 2 : bl) @(posedge clk_sys);
            v[i] = txd;
        end
    endtask
endmodule

/* usart_baud_and_frame_config_tb_top.sv */
// Self-checking bench for the serial transceiver over APB.
// Assumes the peer model on the line; the clock pin input is held low.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module usart_baud_and_frame_config_tb_top
    import usart_cfg_pkg::*;
;
    logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, irq, rxd, txd, ck_out, ck_oe_n, er, stb;
    logic [15:0] fv;
    logic [8:0] dat;
    logic [1:0] par;
    int n_errors = 0, checks_done = 0, t0, k, nd, bl, nt;
    usart_baud_and_frame_config dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .rxd(rxd), .txd(txd),
        .ext_clock_pin_in(1'b0), .ext_clock_pin_out(ck_out), .ext_clock_pin_oe_n(ck_oe_n));
    serial_peer_model peer_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // A fresh edge first, so a release never meets the next request in one step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            stop_test();
        end
    endtask
    task automatic wait_irq();
        k = 0;
        while (irq !== 1'b1 && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 400)
        begin
            n_errors++;
            stop_test();
        end
    endtask
    function automatic logic [15:0] frame(logic [8:0] d, int n, logic [1:0] pm);
        logic [15:0] v;
        logic p;
        v = '1;
        v[0] = 1'b0;
        p = 1'b0;
        for (int j = 0; j < n; j++)
        begin
            v[j + 1] = d[j];
            p = p ^ d[j];
        end
        if (pm[1])
            v[n + 1] = p ^ pm[0];
        return v;
    endfunction
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, OFS_SHARED, 32'h0);
        `CHK("ctrl_rst", 8'h86, rd[7:0])
        `CHK("oe_rst", 1'b1, ck_oe_n)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        apb(1'b1, OFS_SHARED, 32'h0);
        apb(1'b1, OFS_BAUD_LO, 32'h1);
        apb(1'b0, OFS_SHARED, 32'h0);
        `CHK("ctrl_kept", 8'h86, rd[7:0])
        $display("test regs done");
        apb(1'b1, OFS_IRQ_EN, 32'h1);
        // Rows 0-7 walk parity and stop codes, 8 is a nine-bit frame, 9 double speed
        for (int i = 0; i < 10; i++)
        begin
            par = i[1:0];
            stb = i[2] && i < 8;
            nd = (i == 8) ? 9 : 8;
            bl = (i == 9) ? 16 : 32;
            dat = {1'b1, 8'h3b + 8'(i * 23)};
            apb(1'b1, OFS_SHARED, {24'h0, 1'b1, 1'b0, par, stb, 2'h3, 1'b0});
            apb(1'b1, OFS_AUX_CTRL, (i == 8) ? 32'hc : ((i == 9) ? 32'h1 : 32'h0));
            apb(1'b1, OFS_IRQ_CLR, 32'hf);
            // The clear lands on the access edge; look once it has settled
            @(posedge clk_sys);
            `CHK("irq_clr", 1'b0, irq)
            apb(1'b1, OFS_DATA, {24'h0, dat[7:0]});
            peer_u.take(2 + nd + par[1], bl, fv, t0);
            `CHK("tx_frame", frame(dat, nd, par), fv)
            wait_irq();
            nt = 2 + nd + par[1] + stb;
            `CHK("tx_len", 1'b1, (peer_u.cyc - t0 >= nt * bl - 3) && (peer_u.cyc - t0 <= nt * bl + 3))
        end
        $display("test tx done");
        apb(1'b1, OFS_SHARED, 32'ha6);
        apb(1'b1, OFS_AUX_CTRL, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        apb(1'b1, OFS_IRQ_CLR, 32'hf);
        peer_u.send(frame(9'h03c, 8, 2'h2), 11, 32);
        repeat (64) @(posedge clk_sys);
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        `CHK("rx_done", 1'b1, rd[IRQ_RX_DONE])
        apb(1'b0, OFS_DATA, 32'h0);
        `CHK("rx_data", 8'h3c, rd[7:0])
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("par_ok", 1'b0, rd[2])
        apb(1'b1, OFS_IRQ_CLR, 32'hf);
        apb(1'b1, OFS_IRQ_EN, 32'h4);
        peer_u.send(frame(9'h03c, 8, 2'h2) ^ 16'h0200, 11, 32);
        wait_irq();
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("par_bad", 1'b1, rd[2])
        apb(1'b1, OFS_IRQ_CLR, 32'h4);
        @(posedge clk_sys);
        `CHK("irq_low", 1'b0, irq)
        $display("test rx done");
        apb(1'b1, OFS_SHARED, 32'hc6);
        apb(1'b1, OFS_AUX_CTRL, 32'h2);
        repeat (2) @(posedge clk_sys);
        `CHK("oe_master", 1'b0, ck_oe_n)
        // Divisor 1 ticks every second clock, so any two edges hold one pin toggle
        stb = ck_out;
        repeat (2) @(posedge clk_sys);
        `CHK("clk_out", ~stb, ck_out)
        apb(1'b1, OFS_AUX_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys);
        `CHK("oe_slave", 1'b1, ck_oe_n)
        $display("test sync done");
        stop_test();
    end
endmodule
